// *** verilog/iec_top.sv ***
`timescale 1ns/10ps
module iec_top #(
	parameter int N_IRQ = 15,
	parameter int N_DMA = 4
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [3:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic                   nmi_i,
	input  wire logic [N_IRQ-1:0]       external_request_pins_n_i,
	input  wire logic [N_IRQ-1:0]       irq_enable_i,
	input  wire logic [2*N_IRQ-1:0]     irq_sense_i,
	input  wire logic [N_IRQ-1:0]       irq_to_xfer_i,
	input  wire logic                   irq_clear_i,
	input  wire logic [4:0]             irq_clear_idx_i,
	input  wire iec_pkg::iec_cpu_evt_t  cpu_evt_i,
	input  wire iec_pkg::iec_ctx_t      cpu_ctx_i,
	input  wire logic [23:0]            stack_pointer_i,
	input  wire logic                   accept_ready_i,
	input  wire logic [3*N_DMA-1:0]     dma_chan_prio_i,
	output iec_pkg::iec_ctx_t           stack_push_o,
	output logic                        stack_push_valid_o,
	output logic [7:0]                  vector_num_o,
	output logic                        vector_valid_o,
	output logic [7:0]                  new_ccr_o,
	output logic [7:0]                  new_exr_o,
	output logic [N_IRQ-1:0]            xfer_trigger_o,
	output logic                        cpu_wins_xfer_o,
	output logic [N_DMA-1:0]            cpu_wins_dma_o,
	output logic [1:0]                  control_mode_o
);
	import iec_pkg::*;

	// Sixteen priority lanes and a five-bit clear index bound the source count
	if (N_IRQ < 1 || N_IRQ > 16) begin : g_bad_irq
		$error("N_IRQ out of range");
	end
	if (N_DMA < 1) begin : g_bad_dma
		$error("N_DMA out of range");
	end

	// ==================================================================
	// Registers
	logic [7:0]  mode_ctrl_reg;
	logic [7:0]  cpu_prio_reg;
	logic [63:0] src_prio_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic        wb_req;
	logic [1:0]  control_mode_sel;
	logic        mode2;
	logic [2:0]  auto_level;

	assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign control_mode_sel = {mode_ctrl_reg[MODE_HI_BIT], mode_ctrl_reg[MODE_LO_BIT]};
	assign mode2 = (control_mode_sel == MODE2_CODE);
	// Mode 0 CONDITION_CODE_REG mask bit 7 maps to full level, otherwise level 0
	assign auto_level = mode2 ? cpu_ctx_i.extended_control_reg[2:0] :
		(cpu_ctx_i.condition_code_reg[7] ? MASK_LEVEL_MAX : LEVEL_LOW);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_ctrl_reg <= MODE_CTRL_RST;
		end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_MODE_CTRL) begin
			// Prohibited mode codes are stored as written; software must avoid them
			mode_ctrl_reg <= wb_dat_i[7:0] & MODE_CTRL_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_prio_reg <= CPU_PRIO_RST;
		end else begin
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CPU_PRIO)
				cpu_prio_reg[7:3] <= wb_dat_i[7:3];
			if (cpu_prio_reg[AUTO_PS_BIT])
				cpu_prio_reg[2:0] <= auto_level;
			else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CPU_PRIO)
				cpu_prio_reg[2:0] <= wb_dat_i[2:0];
		end
	end

	// Source priority levels, one 4-bit lane per IRQ, reset to level 7
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_prio_reg <= {16{4'h7}};
		end else if (wb_req && wb_we_i) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b] && wb_adr_i == ADDR_SRC_PRIO0)
					src_prio_reg[8*b +: 8] <= wb_dat_i[8*b +: 8] & 8'h77;
				if (wb_sel_i[b] && wb_adr_i == ADDR_SRC_PRIO1)
					src_prio_reg[32+8*b +: 8] <= wb_dat_i[8*b +: 8] & 8'h77;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					ADDR_MODE_CTRL: rdata_reg <= {24'h000000, mode_ctrl_reg};
					ADDR_CPU_PRIO:  rdata_reg <= {24'h000000, cpu_prio_reg};
					ADDR_SRC_PRIO0: rdata_reg <= src_prio_reg[31:0];
					ADDR_SRC_PRIO1: rdata_reg <= src_prio_reg[63:32];
					default:        rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// ==================================================================
	// Pin synchronisers and request detection
	logic [N_IRQ:0] pin_s1;
	logic [N_IRQ:0] pin_s2;
	logic [N_IRQ:0] pin_s3;
	logic [N_IRQ-1:0] irq_flag_reg;
	logic             nmi_flag_reg;
	logic             nmi_edge;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1 <= '1;
			pin_s2 <= '1;
			pin_s3 <= '1;
		end else begin
			pin_s1 <= {nmi_i, external_request_pins_n_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	assign nmi_edge = mode_ctrl_reg[NMI_EDGE_BIT] ? (pin_s2[N_IRQ] && !pin_s3[N_IRQ])
		: (!pin_s2[N_IRQ] && pin_s3[N_IRQ]);

	generate
		for (genvar i = 0; i < N_IRQ; i++) begin : g_sense
			logic fall;
			logic rise;
			logic hit;
			logic clr;
			assign fall = !pin_s2[i] && pin_s3[i];
			assign rise = pin_s2[i] && !pin_s3[i];
			always_comb begin
				case (irq_sense_i[2*i +: 2])
					SENSE_LOW:  hit = !pin_s2[i];
					SENSE_FALL: hit = fall;
					SENSE_RISE: hit = rise;
					SENSE_BOTH: hit = fall || rise;
					default:    hit = 1'b0;
				endcase
			end
			assign clr = irq_clear_i && irq_clear_idx_i == 5'(i);
			always_ff @(posedge clk_i) begin
				if (rst_i)
					irq_flag_reg[i] <= 1'b0;
				else if (hit)
					irq_flag_reg[i] <= 1'b1; // Set beats clear
				else if (clr)
					irq_flag_reg[i] <= 1'b0;
			end
			always_ff @(posedge clk_i) begin
				if (rst_i)
					xfer_trigger_o[i] <= 1'b0;
				else
					xfer_trigger_o[i] <= hit && irq_enable_i[i] && irq_to_xfer_i[i];
			end
		end
	endgenerate

	// ==================================================================
	// Exception selection
	typedef enum logic [1:0] { IEC_IDLE, IEC_PUSH, IEC_VECTOR } iec_state_t;
	iec_state_t state_reg;
	logic       fixed_req;
	logic [7:0] fixed_vec;
	logic       mask_req;
	logic [7:0] mask_vec;
	logic [2:0] best_lvl;
	logic       is_trap;
	logic       is_illegal;

	always_comb begin
		fixed_req  = 1'b1;
		fixed_vec  = VEC_NMI;
		is_trap    = 1'b0;
		is_illegal = 1'b0;
		// Fixed-priority sources bypass every mask
		if (nmi_flag_reg || nmi_edge)
			fixed_vec = VEC_NMI;
		else if (cpu_evt_i.cpu_addr_err || stack_pointer_i[0])
			fixed_vec = VEC_CPU_AERR;
		else if (cpu_evt_i.dma_addr_err)
			fixed_vec = VEC_DMA_AERR;
		else if (cpu_evt_i.trap) begin
			fixed_vec = VEC_TRAP0 + {6'h00, cpu_evt_i.trap_num};
			is_trap = 1'b1;
		end else if (cpu_evt_i.undef_op) begin
			fixed_vec  = VEC_ILLEGAL;
			is_illegal = 1'b1;
		end else if (cpu_evt_i.slot_multiword || cpu_evt_i.slot_pc_write) begin
			fixed_vec  = VEC_SLOT_ILL;
			is_illegal = 1'b1;
		end else if (cpu_evt_i.trace && mode2)
			fixed_vec = VEC_TRACE;
		else
			fixed_req = 1'b0;
	end

	always_comb begin
		mask_req = 1'b0;
		mask_vec = VEC_IRQ0;
		best_lvl = LEVEL_LOW;
		// Lowest index wins among equal levels
		for (int i = N_IRQ - 1; i >= 0; i--) begin
			if (irq_flag_reg[i] && irq_enable_i[i] && !irq_to_xfer_i[i]) begin
				if (mode2 ? (src_prio_reg[4*i +: 3] > cpu_ctx_i.extended_control_reg[2:0])
					: !cpu_ctx_i.condition_code_reg[7]) begin
					if (!mask_req || src_prio_reg[4*i +: 3] >= best_lvl) begin
						mask_req = 1'b1;
						best_lvl = src_prio_reg[4*i +: 3];
						mask_vec = VEC_IRQ0 + 8'(i);
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			nmi_flag_reg <= 1'b0;
		// A taken edge is consumed at once; a new edge while one waits stays pending
		else if (nmi_edge && nmi_flag_reg)
			nmi_flag_reg <= 1'b1;
		else if (state_reg == IEC_IDLE && accept_ready_i && fixed_req && fixed_vec == VEC_NMI)
			nmi_flag_reg <= 1'b0;
		else if (nmi_edge)
			nmi_flag_reg <= 1'b1;
	end

	// ==================================================================
	// Entry sequence: push context, then vector with updated masks
	logic [7:0] ccr_calc;
	logic [7:0] exr_calc;
	logic       take;

	assign take = state_reg == IEC_IDLE && accept_ready_i && (fixed_req || mask_req);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg          <= IEC_IDLE;
			stack_push_o       <= '0;
			stack_push_valid_o <= 1'b0;
			vector_valid_o     <= 1'b0;
			vector_num_o       <= 8'h00;
			ccr_calc           <= 8'h00;
			exr_calc           <= 8'h00;
		end else begin
			stack_push_valid_o <= 1'b0;
			vector_valid_o     <= 1'b0;
			case (state_reg)
				IEC_IDLE: begin
					if (take) begin
						stack_push_o       <= cpu_ctx_i;
						stack_push_valid_o <= 1'b1;
						vector_num_o       <= fixed_req ? fixed_vec : mask_vec;
						ccr_calc           <= cpu_ctx_i.condition_code_reg | 8'h80;
						exr_calc           <= cpu_ctx_i.extended_control_reg;
						if (mode2) begin
							exr_calc[7] <= 1'b0;
							if (fixed_req && !is_illegal)
								exr_calc[2:0] <= is_trap ? MASK_LEVEL_MAX : MASK_LEVEL_MAX;
							else if (!fixed_req)
								exr_calc[2:0] <= best_lvl;
						end
						state_reg <= IEC_PUSH;
					end
				end
				IEC_PUSH: begin
					vector_valid_o <= 1'b1;
					state_reg      <= IEC_VECTOR;
				end
				IEC_VECTOR: state_reg <= IEC_IDLE;
				default:    state_reg <= IEC_IDLE;
			endcase
		end
	end
	assign new_ccr_o = ccr_calc;
	assign new_exr_o = exr_calc;

	// ==================================================================
	// CPU versus transfer controller arbitration
	logic [2:0] cpu_lvl;
	assign cpu_lvl = cpu_prio_reg[CPU_PL_LSB +: 3];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_wins_xfer_o <= 1'b0;
			cpu_wins_dma_o  <= '0;
			control_mode_o  <= MODE0_CODE;
		end else begin
			control_mode_o  <= control_mode_sel;
			// Ties go to the transfer side so the CPU never starves it
			cpu_wins_xfer_o <= cpu_prio_reg[CPU_PE_BIT] &&
				(cpu_lvl > cpu_prio_reg[XFER_P_LSB +: 3]);
			for (int c = 0; c < N_DMA; c++)
				cpu_wins_dma_o[c] <= cpu_prio_reg[CPU_PE_BIT] &&
					(cpu_lvl > dma_chan_prio_i[3*c +: 3]);
		end
	end

	// ==================================================================
	// Checks
	a_entry_vector_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		stack_push_valid_o |=> vector_valid_o) else $error("vector not after push");
	a_mask_set_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		vector_valid_o |-> new_ccr_o[7]) else $error("mask bit not set");
	a_trap_vector_pick: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && fixed_req && is_trap) |=>
		vector_num_o == VEC_TRAP0 + {6'h00, $past(cpu_evt_i.trap_num)})
		else $error("trap vector wrong");
	a_trap_always_taken: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == IEC_IDLE && accept_ready_i && cpu_evt_i.trap) |=> stack_push_valid_o)
		else $error("trap not taken");
	a_trace_clear_m2: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && mode2) |=> !exr_calc[7]) else $error("trace not cleared");
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_ctrl_reg & ~MODE_CTRL_WMASK) == 8'h00) else $error("reserved bits set");
	a_auto_level_track: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(cpu_prio_reg[AUTO_PS_BIT]) |-> cpu_lvl == $past(auto_level))
		else $error("auto level stale");
	a_cpu_lowest_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(cpu_prio_reg[CPU_PE_BIT]) |-> !cpu_wins_xfer_o && cpu_wins_dma_o == '0)
		else $error("cpu won while disabled");
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule

// *** verilog/iec_pkg.sv ***
package iec_pkg;
	// ==================================================================
	// Register map (Wishbone byte addresses, one word apart)
	localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
	localparam logic [3:0] ADDR_CPU_PRIO  = 4'h4;
	localparam logic [3:0] ADDR_SRC_PRIO0 = 4'h8;
	localparam logic [3:0] ADDR_SRC_PRIO1 = 4'hC;

	localparam logic [7:0] MODE_CTRL_RST = 8'h00;
	localparam logic [7:0] CPU_PRIO_RST  = 8'h00;
	localparam logic [7:0] MODE_CTRL_WMASK = 8'h38;

	// Mode control field positions
	localparam int MODE_HI_BIT = 5;
	localparam int MODE_LO_BIT = 4;
	localparam int NMI_EDGE_BIT = 3;
	// CPU priority control field positions
	localparam int CPU_PE_BIT = 7;
	localparam int XFER_P_LSB = 4;
	localparam int AUTO_PS_BIT = 3;
	localparam int CPU_PL_LSB = 0;

	localparam logic [1:0] MODE0_CODE = 2'h0;
	localparam logic [1:0] MODE2_CODE = 2'h2;
	localparam logic [2:0] MASK_LEVEL_MAX = 3'h7;
	localparam logic [2:0] LEVEL_LOW = 3'h0;
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_FALL = 2'h1;
	localparam logic [1:0] SENSE_RISE = 2'h2;
	localparam logic [1:0] SENSE_BOTH = 2'h3;

	// Vector numbers
	localparam logic [7:0] VEC_NMI      = 8'h07;
	localparam logic [7:0] VEC_TRAP0    = 8'h08;
	localparam logic [7:0] VEC_TRACE    = 8'h05;
	localparam logic [7:0] VEC_ILLEGAL  = 8'h04;
	localparam logic [7:0] VEC_SLOT_ILL = 8'h06;
	localparam logic [7:0] VEC_CPU_AERR = 8'h0C;
	localparam logic [7:0] VEC_DMA_AERR = 8'h0D;
	localparam logic [7:0] VEC_IRQ0     = 8'h40;

	typedef struct packed {
		logic [23:0] pc;
		logic [7:0]  condition_code_reg;
		logic [7:0]  extended_control_reg;
	} iec_ctx_t;

	typedef struct packed {
		logic       trap;
		logic [1:0] trap_num;
		logic       undef_op;
		logic       slot_multiword;
		logic       slot_pc_write;
		logic       trace;
		logic       cpu_addr_err;
		logic       dma_addr_err;
	} iec_cpu_evt_t;
endpackage

// *** tb/iec_cpu_model.sv ***
`timescale 1ns/10ps
// ==========================================
// CPU side: holds the live context and loads the entry values
module iec_cpu_model (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             set_i,
	input  wire iec_pkg::iec_ctx_t set_ctx_i,
	input  wire logic             slow_i,
	input  wire logic             odd_sp_i,
	input  wire logic             vector_valid_i,
	input  wire logic [7:0]       new_ccr_i,
	input  wire logic [7:0]       new_exr_i,
	output iec_pkg::iec_ctx_t     ctx_o,
	output logic [23:0]           sp_o,
	output logic                  ready_o
);
	import iec_pkg::*;
	logic [1:0] cnt_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctx_o <= '0;
		end else if (set_i) begin
			ctx_o <= set_ctx_i;
		end else if (vector_valid_i) begin
			ctx_o.condition_code_reg <= new_ccr_i;
			ctx_o.extended_control_reg <= new_exr_i;
		end
	end
	always_ff @(posedge clk_i) begin
		cnt_reg <= rst_i ? 2'h0 : cnt_reg + 2'h1;
	end
	// Slow mode reaches a boundary only every fourth cycle
	assign ready_o = !rst_i && (!slow_i || cnt_reg == 2'h3);
	// Pointer kept even unless a fault is commanded
	assign sp_o = {23'h7FFF80, odd_sp_i};
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	import iec_pkg::*;
	typedef struct packed {
		logic [7:0] v;
		logic [7:0] c;
		logic [7:0] e;
		iec_ctx_t   x;
	} iec_exp_t;
	logic         clk_i = 0, rst_i = 1, cyc = 0, we = 0, nmi = 1, clr = 0;
	logic         set = 0, slow = 0, odd = 0, ready, ack, pv, vv, wx;
	logic [3:0]   adr = 0, wd;
	logic [31:0]  wdat = 0, rdat, dat_o;
	logic [14:0]  pins = '1, en = 0, to_x = 0, xtrig;
	logic [29:0]  sense = 0;
	logic [4:0]   clr_idx = 0;
	logic [11:0]  dprio = 0;
	logic [7:0]   vec, nccr, nexr;
	logic [1:0]   mode, md = 0;
	logic [23:0]  sp;
	iec_cpu_evt_t evt = '0;
	iec_ctx_t     ctx, push, sctx = '0;
	iec_exp_t     q[$];
	iec_exp_t     ex;
	int           err_count = 0, samples_checked = 0, seed = 9153;
	always #10 clk_i = ~clk_i;
	iec_top iec_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .nmi_i(nmi), .external_request_pins_n_i(pins), .irq_enable_i(en),
		.irq_sense_i(sense), .irq_to_xfer_i(to_x), .irq_clear_i(clr),
		.irq_clear_idx_i(clr_idx), .cpu_evt_i(evt), .cpu_ctx_i(ctx), .stack_pointer_i(sp),
		.accept_ready_i(ready), .dma_chan_prio_i(dprio), .stack_push_o(push),
		.stack_push_valid_o(pv), .vector_num_o(vec), .vector_valid_o(vv),
		.new_ccr_o(nccr), .new_exr_o(nexr), .xfer_trigger_o(xtrig),
		.cpu_wins_xfer_o(wx), .cpu_wins_dma_o(wd), .control_mode_o(mode));
	iec_cpu_model iec_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .set_i(set),
		.set_ctx_i(sctx), .slow_i(slow), .odd_sp_i(odd), .vector_valid_i(vv),
		.new_ccr_i(nccr), .new_exr_i(nexr), .ctx_o(ctx), .sp_o(sp), .ready_o(ready));
	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected extended register: k 0 full mask, 1 illegal, 2 maskable at level l
	function automatic logic [7:0] xexr(int k, logic [7:0] e, logic [2:0] l);
		if (md != MODE2_CODE) return e;
		if (k == 1) return e & 8'h7F;
		return {1'b0, e[6:3], k == 2 ? l : MASK_LEVEL_MAX};
	endfunction
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		cyc <= 0;
		we <= 0;
		if (n >= 50) err_count++;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] x);
		bus(0, a, 0);
		`CHK(rdat, x)
	endtask
	task automatic set_mode(input logic [1:0] m, input logic g);
		bus(1, ADDR_MODE_CTRL, {26'h0, m, g, 3'h0});
		md = m;
		@(posedge clk_i);
	endtask
	task automatic set_ctx(input iec_ctx_t c);
		@(posedge clk_i);
		set <= 1;
		sctx <= c;
		@(posedge clk_i);
		set <= 0;
		@(posedge clk_i);
	endtask
	task automatic clear(input int n);
		@(posedge clk_i);
		clr <= 1;
		clr_idx <= 5'(n);
		@(posedge clk_i);
		clr <= 0;
	endtask
	task automatic expect_entry(input logic [7:0] v, input int k, input logic [2:0] l);
		q.push_back('{v, ctx.condition_code_reg | 8'h80, xexr(k, ctx.extended_control_reg, l), ctx});
	endtask
	task automatic drain();
		for (int n = 0; n < 60 && q.size() > 0; n++) @(posedge clk_i);
		`CHK(q.size(), 0)
		repeat (3) @(posedge clk_i);
	endtask
	task automatic fire(input iec_cpu_evt_t e, input logic f);
		int n;
		n = 0;
		@(posedge clk_i);
		evt <= e;
		odd <= f;
		do @(negedge clk_i); while (pv !== 1'b1 && ++n < 40);
		@(posedge clk_i);
		evt <= '0;
		odd <= 0;
		drain();
	endtask
	// Every entry is held against the queue of expected entries
	always @(negedge clk_i) if (!rst_i) begin
		if (pv === 1'b1) `CHK(push, q[0].x)
		if (vv === 1'b1) begin
			ex = q.pop_front();
			`CHK({vec, nccr, nexr}, {ex.v, ex.c, ex.e})
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#400us;
		err_count++;
		conclude();
	end
	initial begin
		iec_cpu_evt_t e;
		logic [31:0]  r;
		int           n;
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		rdc(ADDR_MODE_CTRL, 32'h0);
		rdc(ADDR_CPU_PRIO, 32'h0);
		r = rnd();
		bus(1, ADDR_MODE_CTRL, r | 32'hC7);
		rdc(ADDR_MODE_CTRL, r & 32'h38);
		bus(1, 4'h2, 32'hFF);
		rdc(4'h2, 32'h0);
		for (int m = 0; m < 4; m++) begin
			set_mode(m[1:0], 0);
			`CHK(mode, m[1:0])
		end
		$display("registers done");
		for (int i = 0; i < 2; i++) begin
			set_mode(i ? MODE2_CODE : MODE0_CODE, 0);
			slow <= i[0];
			for (int t = 0; t < 9 + i; t++) begin
				set_ctx(iec_ctx_t'(40'({rnd(), rnd()}) & 40'hFFFFFFFF7F));
				expect_entry(t < 4 ? VEC_TRAP0 + 8'(t) : t == 4 ? VEC_ILLEGAL :
					t < 7 ? VEC_SLOT_ILL : t == 7 ? VEC_CPU_AERR :
					t == 8 ? VEC_DMA_AERR : VEC_TRACE, t > 3 && t < 7, 0);
				e = '0;
				e.trap = t < 4 || t == 7;
				e.trap_num = t[1:0];
				e.undef_op = t == 4;
				e.slot_multiword = t == 5;
				e.slot_pc_write = t == 6;
				e.dma_addr_err = t == 8;
				e.trace = t == 9;
				fire(e, t == 7);
			end
		end
		slow <= 0;
		$display("instruction entries done");
		for (int g = 0; g < 2; g++) begin
			set_mode(MODE0_CODE, g[0]);
			set_ctx('{24'h0, 8'h80, 8'h0});
			expect_entry(VEC_NMI, 0, 0);
			nmi <= g[0];
			drain();
		end
		nmi <= 0;
		repeat (10) @(posedge clk_i);
		$display("nmi done");
		for (int s = 0; s < 4; s++) begin
			n = s * 4 + 1;
			en <= 0;
			sense[2*n +: 2] <= s[1:0];
			pins[n] <= s < 2;
			repeat (6) @(posedge clk_i);
			clear(n);
			en[n] <= 1;
			set_ctx('0);
			expect_entry(VEC_IRQ0 + 8'(n), 2, 0);
			@(posedge clk_i) pins[n] <= s > 1;
			drain();
			en <= 0;
			pins[n] <= 1;
			repeat (6) @(posedge clk_i);
			clear(n);
		end
		set_mode(MODE2_CODE, 0);
		sense[5:4] <= SENSE_FALL;
		clear(2);
		en[2] <= 1;
		set_ctx('{24'h0, 8'h0, 8'h86});
		expect_entry(VEC_IRQ0 + 8'h2, 2, 3'h7);
		pins[2] <= 0;
		drain();
		pins[2] <= 1;
		repeat (6) @(posedge clk_i);
		clear(2);
		pins[2] <= 0;
		repeat (20) @(posedge clk_i);
		`CHK(q.size(), 0)
		en <= 0;
		clear(2);
		sense[7:6] <= SENSE_FALL;
		to_x[3] <= 1;
		en[3] <= 1;
		@(posedge clk_i) pins[3] <= 0;
		n = 0;
		do @(negedge clk_i); while (xtrig === 15'h0 && ++n < 40);
		`CHK(xtrig, 15'h0008)
		en <= 0;
		$display("external requests done");
		dprio <= 12'hD29;
		set_ctx('{24'h0, 8'h0, 8'h03});
		bus(1, ADDR_CPU_PRIO, 32'hBA);
		rdc(ADDR_CPU_PRIO, 32'hBB);
		`CHK(wx, 1'b0)
		set_ctx('{24'h0, 8'h0, 8'h05});
		rdc(ADDR_CPU_PRIO, 32'hBD);
		`CHK(wx, 1'b1)
		bus(1, ADDR_CPU_PRIO, 32'hB5);
		rdc(ADDR_CPU_PRIO, 32'hB5);
		`CHK({wx, wd}, 5'h15)
		bus(1, ADDR_CPU_PRIO, 32'h35);
		rdc(ADDR_CPU_PRIO, 32'h35);
		`CHK({wx, wd}, 5'h00)
		set_mode(MODE0_CODE, 0);
		set_ctx('{24'h0, 8'h80, 8'h0});
		bus(1, ADDR_CPU_PRIO, 32'hB8);
		rdc(ADDR_CPU_PRIO, 32'hBF);
		$display("priority done");
		conclude();
	end
endmodule
